// ==== mmc_codec.sv ====
// Management message payload codec: parses received control requests and
// event indications, expands run-length compressed values, and frames the
// confirmations, event responses and locally raised event indications.
// Assumes an octet stream from the data link on each side, one clock.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module mmc_codec
  import mmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire mmc_msg_t rx_type,
  input wire logic rx_compressed,
  output logic rx_ready,
  output logic hdr_valid,
  output mmc_msg_t hdr_type,
  output logic [7:0] hdr_control,
  output logic [3:0] hdr_request_type,
  output logic [47:0] hdr_requester_mac,
  output logic [15:0] hdr_value_length,
  output logic hdr_ack_requested,
  output logic hdr_compressed,
  output logic val_valid,
  output logic [7:0] val_data,
  output logic val_last,
  input wire logic val_ready,
  output logic pat_valid,
  output logic [MMC_PAT_W-1:0] pat_data,
  input wire logic pat_ready,
  output logic rle_done,
  output logic rle_error,
  input wire logic [15:0] resp_value_length,
  input wire logic evt_send,
  input wire logic [7:0] evt_control,
  input wire logic evt_ack,
  input wire logic [15:0] evt_value_length,
  output logic evt_busy,
  input wire logic tx_pl_valid,
  input wire logic [7:0] tx_pl_data,
  output logic tx_pl_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  output mmc_msg_t tx_type,
  input wire logic tx_ready
);
  mmc_rx_t rx_state;
  mmc_dec_t dec_state;
  logic [1:0] ctrl;
  logic [15:0] rx_count;
  logic [3:0] rx_idx;
  logic [15:0] rx_left;
  logic [15:0] len_acc;
  logic rx_rle;
  logic rx_take;
  logic hdr_end;
  logic [15:0] hdr_len_now;
  logic br_in_valid;
  logic br_in_ready;
  logic br_take;
  logic [4:0] br_take_w;
  logic [15:0] br_field;
  logic [5:0] br_avail;
  logic br_clear;
  logic [3:0] m_w;
  logic [3:0] n_w;
  logic [14:0] rep;
  logic [MMC_PAT_W-1:0] pattern;
  logic out_free;
  logic need_bits;
  logic starved;
  logic emit;
  logic pend_cnf;
  logic pend_rsp;
  logic pend_evt;
  logic [7:0] cnf_control;
  logic [7:0] rsp_control;
  logic [7:0] evt_ctl_q;
  logic evt_ack_q;
  logic [15:0] evt_len_q;
  logic fr_start;
  logic fr_busy;
  logic [31:0] fr_hdr;
  logic [2:0] fr_hdr_len;
  logic [15:0] fr_pay_len;
  mmc_msg_t fr_type;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= MMC_CTRL_RESET;
    end else if (reg_write && reg_addr == MMC_REG_CTRL) begin
      ctrl <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      case (reg_addr)
        MMC_REG_CTRL: reg_rdata <= {30'h0, ctrl};
        MMC_REG_STATUS: reg_rdata <= {28'h0, pend_evt, fr_busy,
                                      dec_state != MMC_D_IDLE,
                                      rx_state != MMC_RX_IDLE};
        MMC_REG_RX_COUNT: reg_rdata <= {16'h0, rx_count};
        MMC_REG_LAST: reg_rdata <= {8'h0, hdr_control, hdr_value_length};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive header parsing

  // New messages wait while a reply is still owed, so no reply is dropped
  always_comb begin
    case (rx_state)
      MMC_RX_IDLE: rx_ready = !pend_cnf && !pend_rsp;
      MMC_RX_HDR: rx_ready = 1'b1;
      MMC_RX_VALUE: begin
        if (!rx_rle) begin
          rx_ready = !val_valid || val_ready;
        end else if (dec_state == MMC_D_DONE) begin
          rx_ready = 1'b1;
        end else begin
          rx_ready = br_in_ready;
        end
      end
      // The next start is left for idle to take, so that message survives
      MMC_RX_SKIP: rx_ready = !rx_start;
      default: rx_ready = 1'b0;
    endcase
  end

  assign rx_take = rx_valid && rx_ready;
  assign hdr_end = (rx_state == MMC_RX_HDR) && rx_take &&
                   (hdr_type == MMC_MSG_CTRL_REQ ? rx_idx == MMC_OCT_REQ_LEN_LO
                                                 : rx_idx == MMC_OCT_IND_FLAGS);
  // The request's low length octet is also its last header octet
  assign hdr_len_now = (hdr_type == MMC_MSG_CTRL_REQ) ? {len_acc[7:0], rx_data} : len_acc;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_state <= MMC_RX_IDLE;
      rx_idx <= '0;
      rx_left <= '0;
    end else begin
      case (rx_state)
        MMC_RX_IDLE: begin
          if (rx_take && rx_start) begin
            rx_idx <= 4'h1;
            if (rx_type == MMC_MSG_CTRL_REQ || rx_type == MMC_MSG_EVT_IND) begin
              rx_state <= MMC_RX_HDR;
            end else begin
              rx_state <= MMC_RX_SKIP;
            end
          end
        end
        MMC_RX_HDR: begin
          if (rx_take) begin
            rx_idx <= rx_idx + 4'h1;
          end
          if (hdr_end) begin
            rx_left <= hdr_len_now;
            rx_state <= (hdr_len_now == 16'h0) ? MMC_RX_IDLE : MMC_RX_VALUE;
          end
        end
        MMC_RX_VALUE: begin
          if (rx_take && rx_left != 16'h0) begin
            rx_left <= rx_left - 16'h1;
          end
          if (!rx_rle && rx_take && rx_left == 16'h1) begin
            rx_state <= MMC_RX_IDLE;
          end else if (rx_rle && rx_left == 16'h0 && dec_state == MMC_D_DONE) begin
            rx_state <= MMC_RX_IDLE;
          end
        end
        MMC_RX_SKIP: begin
          // Messages not addressed to this role are dropped up to the next start
          if (rx_valid && rx_start) begin
            rx_state <= MMC_RX_IDLE;
          end
        end
        default: rx_state <= MMC_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hdr_type <= MMC_MSG_CTRL_REQ;
      hdr_control <= '0;
      hdr_requester_mac <= '0;
      len_acc <= '0;
      hdr_ack_requested <= 1'b0;
      rx_rle <= 1'b0;
    end else if (rx_state == MMC_RX_IDLE && rx_take && rx_start) begin
      hdr_type <= rx_type;
      hdr_control <= rx_data;
      hdr_ack_requested <= 1'b0;
      // Decoding a compressed value needs both local and peer support
      rx_rle <= rx_compressed && ctrl[MMC_CTRL_RLE_LOCAL] && ctrl[MMC_CTRL_RLE_PEER];
    end else if (rx_state == MMC_RX_HDR && rx_take) begin
      if (hdr_type == MMC_MSG_CTRL_REQ && rx_idx < MMC_OCT_REQ_LEN_HI) begin
        hdr_requester_mac <= {hdr_requester_mac[39:0], rx_data};
      end else if (hdr_type == MMC_MSG_EVT_IND && rx_idx == MMC_OCT_IND_FLAGS) begin
        hdr_ack_requested <= rx_data[MMC_ACK_BIT];
      end else begin
        len_acc <= {len_acc[7:0], rx_data};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hdr_valid <= 1'b0;
      hdr_value_length <= '0;
      hdr_compressed <= 1'b0;
      rx_count <= '0;
    end else begin
      hdr_valid <= hdr_end;
      if (hdr_end) begin
        hdr_value_length <= hdr_len_now;
        hdr_compressed <= rx_rle;
        rx_count <= rx_count + 16'h1;
      end
    end
  end

  assign hdr_request_type = hdr_control[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Uncompressed value pass-through

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      val_valid <= 1'b0;
      val_data <= '0;
      val_last <= 1'b0;
    end else if (rx_state == MMC_RX_VALUE && !rx_rle && rx_take) begin
      val_valid <= 1'b1;
      val_data <= rx_data;
      val_last <= (rx_left == 16'h1);
    end else if (val_ready) begin
      val_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run-length expansion

  assign br_in_valid = rx_valid && rx_state == MMC_RX_VALUE && rx_rle &&
                       rx_left != 16'h0 && dec_state != MMC_D_DONE;
  // Once the end group is seen the rest of the value, padding included, is dropped
  assign br_clear = (dec_state == MMC_D_DONE) || (dec_state == MMC_D_IDLE);
  assign out_free = !pat_valid || pat_ready;

  always_comb begin
    case (dec_state)
      MMC_D_HDR: br_take_w = MMC_RLE_HDR_W;
      MMC_D_COUNT: br_take_w = {1'b0, m_w};
      MMC_D_PATTERN: br_take_w = {1'b0, n_w};
      MMC_D_SPECIAL: br_take_w = MMC_RLE_SPECIAL_W;
      MMC_D_LITERAL: br_take_w = {1'b0, n_w};
      default: br_take_w = 5'h00;
    endcase
  end

  assign need_bits = (dec_state == MMC_D_HDR) || (dec_state == MMC_D_COUNT) ||
                     (dec_state == MMC_D_PATTERN) || (dec_state == MMC_D_SPECIAL) ||
                     (dec_state == MMC_D_LITERAL);
  assign br_take = need_bits && br_avail >= 6'(br_take_w) &&
                   (dec_state != MMC_D_LITERAL || out_free);
  // Value ran out before the end group arrived
  assign starved = need_bits && br_avail < 6'(br_take_w) &&
                   rx_left == 16'h0 && !br_in_valid;
  assign emit = (dec_state == MMC_D_REPEAT && out_free) ||
                (dec_state == MMC_D_LITERAL && br_take);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dec_state <= MMC_D_IDLE;
      m_w <= '0;
      n_w <= '0;
      rep <= '0;
      pattern <= '0;
    end else if (starved) begin
      dec_state <= MMC_D_DONE;
    end else begin
      case (dec_state)
        MMC_D_IDLE: begin
          if (hdr_end && rx_rle && hdr_len_now != 16'h0) begin
            dec_state <= MMC_D_HDR;
          end
        end
        MMC_D_HDR: begin
          if (br_take) begin
            m_w <= br_field[MMC_RLE_M_LSB +: 4];
            n_w <= br_field[MMC_RLE_N_LSB +: 4];
            dec_state <= MMC_D_COUNT;
          end
        end
        MMC_D_COUNT: begin
          if (br_take) begin
            rep <= br_field[14:0];
            if (br_field == 16'h0) begin
              dec_state <= MMC_D_SPECIAL;
            end else begin
              dec_state <= MMC_D_PATTERN;
            end
          end
        end
        MMC_D_PATTERN: begin
          if (br_take) begin
            pattern <= br_field[MMC_PAT_W-1:0];
            dec_state <= MMC_D_REPEAT;
          end
        end
        MMC_D_REPEAT: begin
          if (emit) begin
            rep <= rep - 15'h1;
            if (rep == 15'h1) begin
              dec_state <= MMC_D_COUNT;
            end
          end
        end
        MMC_D_SPECIAL: begin
          if (br_take) begin
            rep <= {7'h0, br_field[7:0]};
            dec_state <= (br_field[7:0] == 8'h0) ? MMC_D_DONE : MMC_D_LITERAL;
          end
        end
        MMC_D_LITERAL: begin
          if (emit) begin
            rep <= rep - 15'h1;
            if (rep == 15'h1) begin
              dec_state <= MMC_D_COUNT;
            end
          end
        end
        MMC_D_DONE: begin
          if (rx_left == 16'h0) begin
            dec_state <= MMC_D_IDLE;
          end
        end
        default: dec_state <= MMC_D_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pat_valid <= 1'b0;
      pat_data <= '0;
      rle_done <= 1'b0;
      rle_error <= 1'b0;
    end else begin
      rle_done <= (dec_state == MMC_D_DONE) && (rx_left == 16'h0);
      rle_error <= starved;
      if (emit) begin
        pat_valid <= 1'b1;
        pat_data <= (dec_state == MMC_D_REPEAT) ? pattern : br_field[MMC_PAT_W-1:0];
      end else if (pat_ready) begin
        pat_valid <= 1'b0;
      end
    end
  end

  mmc_bit_reader #(
    .BUF_W(32)
  ) u_bits (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(br_clear),
    .in_valid(br_in_valid),
    .in_data(rx_data),
    .in_ready(br_in_ready),
    .take(br_take),
    .take_w(br_take_w),
    .field(br_field),
    .avail(br_avail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Replies and local events

  assign evt_busy = pend_evt;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pend_cnf <= 1'b0;
      pend_rsp <= 1'b0;
      pend_evt <= 1'b0;
      cnf_control <= '0;
      rsp_control <= '0;
      evt_ctl_q <= '0;
      evt_ack_q <= 1'b0;
      evt_len_q <= '0;
    end else begin
      if (hdr_valid && hdr_type == MMC_MSG_CTRL_REQ) begin
        pend_cnf <= 1'b1;
        cnf_control <= hdr_control & MMC_REQ_TYPE_MASK;
      end else if (fr_start && fr_type == MMC_MSG_CTRL_CNF) begin
        pend_cnf <= 1'b0;
      end
      if (hdr_valid && hdr_type == MMC_MSG_EVT_IND && hdr_ack_requested) begin
        pend_rsp <= 1'b1;
        rsp_control <= hdr_control & MMC_REQ_TYPE_MASK;
      end else if (fr_start && fr_type == MMC_MSG_EVT_RSP) begin
        pend_rsp <= 1'b0;
      end
      if (evt_send && !pend_evt) begin
        pend_evt <= 1'b1;
        evt_ctl_q <= evt_control & MMC_REQ_TYPE_MASK;
        evt_ack_q <= evt_ack;
        evt_len_q <= evt_value_length;
      end else if (fr_start && fr_type == MMC_MSG_EVT_IND) begin
        pend_evt <= 1'b0;
      end
    end
  end

  // Owed replies go ahead of local events
  always_comb begin
    fr_type = MMC_MSG_EVT_IND;
    fr_hdr = {evt_ctl_q, evt_len_q, 7'h00, evt_ack_q};
    fr_hdr_len = MMC_IND_HDR_LEN;
    fr_pay_len = evt_len_q;
    if (pend_cnf) begin
      fr_type = MMC_MSG_CTRL_CNF;
      fr_hdr = {cnf_control, resp_value_length, 8'h00};
      fr_hdr_len = MMC_CNF_HDR_LEN;
      fr_pay_len = resp_value_length;
    end else if (pend_rsp) begin
      fr_type = MMC_MSG_EVT_RSP;
      fr_hdr = {rsp_control, resp_value_length, 8'h00};
      fr_hdr_len = MMC_CNF_HDR_LEN;
      fr_pay_len = resp_value_length;
    end
  end

  assign fr_start = !fr_busy && (pend_cnf || pend_rsp || pend_evt);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_type <= MMC_MSG_CTRL_CNF;
    end else if (fr_start) begin
      tx_type <= fr_type;
    end
  end

  mmc_tx_framer u_framer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(fr_start),
    .hdr(fr_hdr),
    .hdr_len(fr_hdr_len),
    .pay_len(fr_pay_len),
    .pl_valid(tx_pl_valid),
    .pl_data(tx_pl_data),
    .pl_ready(tx_pl_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .busy(fr_busy)
  );
endmodule
`default_nettype wire

// ==== mmc_pkg.sv ====
// Shared constants and types for the management message payload codec.
// Assumes a single clock domain and octets carried most significant bit first.
`default_nettype none
package mmc_pkg;
  typedef enum logic [1:0] {
    MMC_MSG_CTRL_REQ = 2'h0,
    MMC_MSG_CTRL_CNF = 2'h1,
    MMC_MSG_EVT_IND = 2'h2,
    MMC_MSG_EVT_RSP = 2'h3
  } mmc_msg_t;
  typedef enum logic [1:0] {
    MMC_RX_IDLE = 2'h0,
    MMC_RX_HDR = 2'h1,
    MMC_RX_VALUE = 2'h2,
    MMC_RX_SKIP = 2'h3
  } mmc_rx_t;
  typedef enum logic [2:0] {
    MMC_D_IDLE = 3'h0,
    MMC_D_HDR = 3'h1,
    MMC_D_COUNT = 3'h2,
    MMC_D_PATTERN = 3'h3,
    MMC_D_REPEAT = 3'h4,
    MMC_D_SPECIAL = 3'h5,
    MMC_D_LITERAL = 3'h6,
    MMC_D_DONE = 3'h7
  } mmc_dec_t;
  // Octet positions inside the message payloads
  localparam logic [3:0] MMC_OCT_REQ_LEN_HI = 4'h7;
  localparam logic [3:0] MMC_OCT_REQ_LEN_LO = 4'h8;
  localparam logic [3:0] MMC_OCT_IND_LEN_HI = 4'h1;
  localparam logic [3:0] MMC_OCT_IND_LEN_LO = 4'h2;
  localparam logic [3:0] MMC_OCT_IND_FLAGS = 4'h3;
  localparam logic [2:0] MMC_CNF_HDR_LEN = 3'h3;
  localparam logic [2:0] MMC_IND_HDR_LEN = 3'h4;
  localparam int MMC_ACK_BIT = 0;
  localparam logic [7:0] MMC_REQ_TYPE_MASK = 8'h0f;
  // Compressed field layout
  localparam logic [4:0] MMC_RLE_HDR_W = 5'h08;
  localparam logic [4:0] MMC_RLE_SPECIAL_W = 5'h08;
  localparam int MMC_RLE_M_LSB = 0;
  localparam int MMC_RLE_N_LSB = 4;
  localparam int MMC_PAT_W = 15;
  // Register map
  localparam logic [3:0] MMC_REG_CTRL = 4'h0;
  localparam logic [3:0] MMC_REG_STATUS = 4'h4;
  localparam logic [3:0] MMC_REG_RX_COUNT = 4'h8;
  localparam logic [3:0] MMC_REG_LAST = 4'hc;
  localparam int MMC_CTRL_RLE_LOCAL = 0;
  localparam int MMC_CTRL_RLE_PEER = 1;
  localparam logic [1:0] MMC_CTRL_RESET = 2'h0;
endpackage
`default_nettype wire

// ==== mmc_bit_reader.sv ====
// Left-aligned bit accumulator: octets in, variable-width fields out.
// Assumes the consumer only takes a field when avail covers its width.
`timescale 1ns/100ps
`default_nettype none
module mmc_bit_reader #(
  parameter int BUF_W = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  input wire logic take,
  input wire logic [4:0] take_w,
  output logic [15:0] field,
  output logic [5:0] avail
);
  localparam logic [5:0] BYTE_W = 6'h08;
  localparam logic [5:0] FILL_MAX = 6'(BUF_W) - BYTE_W;
  logic [BUF_W-1:0] bits;
  logic [BUF_W-1:0] next_bits;
  logic [5:0] next_avail;
  logic [5:0] left;
  logic push;

  assign in_ready = (avail <= FILL_MAX) && !clear;
  assign push = in_valid && in_ready;
  // Fields leave from the top, so the first bit on the wire is the field's msb
  assign field = bits[BUF_W-1 -: 16] >> (5'h10 - take_w);

  always_comb begin
    left = take ? avail - 6'(take_w) : avail;
    next_bits = take ? bits << take_w : bits;
    if (push) begin
      next_bits = next_bits | ({in_data, {(BUF_W-8){1'b0}}} >> left);
    end
    next_avail = push ? left + BYTE_W : left;
  end

  always_ff @(posedge ref_clk) begin
    if (reset || clear) begin
      bits <= '0;
      avail <= '0;
    end else begin
      bits <= next_bits;
      avail <= next_avail;
    end
  end
endmodule
`default_nettype wire

// ==== mmc_tx_framer.sv ====
// Serialises a short header followed by a counted payload onto an octet stream.
// Assumes the caller only starts a frame while busy is low.
`timescale 1ns/100ps
`default_nettype none
module mmc_tx_framer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [31:0] hdr,
  input wire logic [2:0] hdr_len,
  input wire logic [15:0] pay_len,
  input wire logic pl_valid,
  input wire logic [7:0] pl_data,
  output logic pl_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic busy
);
  logic [31:0] shreg;
  logic [2:0] hdr_left;
  logic [15:0] pay_left;
  logic can_load;

  assign can_load = !tx_valid || tx_ready;
  assign pl_ready = can_load && (hdr_left == 3'h0) && (pay_left != 16'h0);
  assign busy = (hdr_left != 3'h0) || (pay_left != 16'h0) || tx_valid;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shreg <= '0;
      hdr_left <= '0;
      pay_left <= '0;
    end else if (start && !busy) begin
      shreg <= hdr;
      hdr_left <= hdr_len;
      pay_left <= pay_len;
    end else if (can_load && hdr_left != 3'h0) begin
      shreg <= shreg << 8;
      hdr_left <= hdr_left - 3'h1;
    end else if (pl_ready && pl_valid) begin
      pay_left <= pay_left - 16'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_last <= 1'b0;
    end else if (can_load && hdr_left != 3'h0) begin
      tx_valid <= 1'b1;
      tx_data <= shreg[31:24];
      tx_last <= (hdr_left == 3'h1) && (pay_left == 16'h0);
    end else if (pl_ready && pl_valid) begin
      tx_valid <= 1'b1;
      tx_data <= pl_data;
      tx_last <= (pay_left == 16'h1);
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== mmc_codec_chk.sv ====
// Port-level checker for mmc_codec, bound to every instance.
// Assumes one clock and the register map of mmc_pkg.
`timescale 1ns/100ps
`default_nettype none
module mmc_codec_chk
  import mmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [7:0] hdr_control,
  input wire logic [3:0] hdr_request_type,
  input wire logic hdr_valid,
  input wire logic pat_valid,
  input wire logic [MMC_PAT_W-1:0] pat_data,
  input wire logic pat_ready,
  input wire logic val_valid,
  input wire logic [7:0] val_data,
  input wire logic val_ready,
  input wire logic rle_done,
  input wire logic rle_error,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire mmc_msg_t tx_type,
  input wire logic tx_ready
);
  logic rle_en;
  logic [2:0] tx_idx;
  always_ff @(posedge ref_clk) begin
    if (reset) rle_en <= 1'b0;
    else if (reg_write && reg_addr == MMC_REG_CTRL) rle_en <= &reg_wdata[1:0];
  end
  // Octet index saturates; only the first four octets matter
  always_ff @(posedge ref_clk) begin
    if (reset) tx_idx <= 3'h0;
    else if (tx_valid && tx_ready) tx_idx <= tx_last ? 3'h0 : tx_idx + 3'(tx_idx != 3'h7);
  end
  ////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_tx_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_tx_held;
    tx_valid && $stable(tx_data) && $stable(tx_last) && $stable(tx_type);
  endsequence
  a_tx_hold: assert property (s_tx_stall |=> s_tx_held)
    else $error("tx octet changed while stalled");
  a_pat_hold: assert property (pat_valid && !pat_ready |=> pat_valid && $stable(pat_data))
    else $error("pattern changed while stalled");
  a_val_hold: assert property (val_valid && !val_ready |=> val_valid && $stable(val_data))
    else $error("value octet changed while stalled");
  a_req_nibble: assert property (hdr_request_type == hdr_control[3:0])
    else $error("request type differs from control octet");
  a_ctl_rsvd: assert property (tx_valid && tx_idx == 3'h0 |-> tx_data[7:4] == 4'h0)
    else $error("reserved control bits sent nonzero");
  a_flag_rsvd: assert property (tx_valid && tx_type == MMC_MSG_EVT_IND && tx_idx == 3'h3
    |-> tx_data[7:1] == 7'h0)
    else $error("reserved flag bits sent nonzero");
  a_rle_gate: assert property (pat_valid |-> rle_en)
    else $error("pattern out without both ends enabled");
  a_end_alone: assert property (!(rle_done && rle_error))
    else $error("done and error together");
  a_hdr_pulse: assert property (hdr_valid |=> !hdr_valid)
    else $error("header strobe longer than one cycle");
  a_tx_kind: assert property (tx_valid |-> tx_type != MMC_MSG_CTRL_REQ)
    else $error("request type on transmit");
endmodule
bind mmc_codec mmc_codec_chk i_chk (.*);
`default_nettype wire

// ==== mmc_peer.sv ====
// Far-side model: drains the transmit octet stream with random stalls.
// Assumes the bench reads and clears got between tests.
`timescale 1ns/100ps
`default_nettype none
module mmc_peer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [14:0] got[$];
  always @(posedge ref_clk) begin
    tx_ready <= !reset && ($urandom % 3 != 0);
    if (tx_valid && tx_ready) got.push_back({6'h0, tx_last, tx_data});
  end
endmodule
`default_nettype wire

// ==== mmc_codec_bench.sv ====
// Self-checking bench: random messages, a compressed value, a local event.
// Assumes mmc_peer drains transmit frames; tx_last rides in bit 8 of got.
`timescale 1ns/100ps
`default_nettype none
module mmc_codec_bench;
  import mmc_pkg::*;
  logic ref_clk = 0, reset = 1, reg_write = 0, reg_read = 0, rx_start = 0, rx_valid = 0;
  logic rx_compressed = 0, val_ready = 0, pat_ready = 0, evt_send = 0, evt_ack = 0;
  logic tx_pl_valid = 1, tx_ready, rx_ready, hdr_valid, hdr_ack_requested, hdr_compressed;
  logic val_valid, val_last, pat_valid, rle_done, rle_error, evt_busy, tx_pl_ready;
  logic tx_valid, tx_last;
  logic [3:0] reg_addr = 0, hdr_request_type;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [7:0] rx_data = 0, evt_control = 0, tx_pl_data = 0, hdr_control, val_data, tx_data;
  logic [15:0] resp_value_length = 16'h0001, evt_value_length = 0, hdr_value_length;
  logic [47:0] hdr_requester_mac;
  logic [MMC_PAT_W-1:0] pat_data;
  mmc_msg_t rx_type = MMC_MSG_CTRL_REQ, hdr_type, tx_type;
  logic [14:0] vq[$], pq[$], eq[$], m[$];
  int fails = 0, num_checks = 0, cyc = 0, dones = 0, errs = 0;
  always #10 ref_clk = ~ref_clk;
  mmc_codec i_dut (.*);
  mmc_peer i_peer (.*);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    val_ready <= ($urandom % 4) != 0;
    pat_ready <= ($urandom % 4) != 0;
    if (val_valid && val_ready) vq.push_back({6'h0, val_last, val_data});
    if (pat_valid && pat_ready) pq.push_back(pat_data);
    if (rle_done) dones <= dones + 1;
    if (rle_error) errs <= errs + 1;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end
  ////////////////////
  task chk(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_q(input logic [14:0] g[$], input logic [14:0] e[$]);
    chk(g.size(), e.size());
    foreach (e[i]) chk(g[i], e[i]);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1;
    @(posedge ref_clk); reg_write <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a; reg_read <= 1;
    @(posedge ref_clk); reg_read <= 0;
    @(negedge ref_clk); chk(reg_rdata, e);
    @(posedge ref_clk);
  endtask
  task send(input mmc_msg_t t);
    rx_type <= t; rx_compressed <= 1;
    foreach (m[i]) begin
      rx_valid <= 1; rx_start <= (i == 0); rx_data <= m[i][7:0];
      do @(negedge ref_clk); while (rx_ready !== 1'b1);
      @(posedge ref_clk);
    end
    rx_valid <= 0; rx_start <= 0;
    // Idle gap also exposes any frame that should not appear
    for (int j = 0; j < 300 && i_peer.got.size() < eq.size(); j++) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
  endtask
  task run(input int k);
    logic [7:0] c, v, p;
    logic [47:0] a;
    c = $urandom; v = $urandom; p = $urandom; a = {$urandom, $urandom};
    tx_pl_data <= p;
    m = {c};
    if (k == 0) for (int i = 5; i >= 0; i--) m.push_back(a[i*8 +: 8]);
    m.push_back(0); m.push_back(1);
    if (k > 0) m.push_back({7'h7f, k == 2});
    m.push_back(v);
    eq = {};
    if (k != 1) eq = {c & 8'h0f, 8'h00, 8'h01, 15'h100 | p};
    send(k == 0 ? MMC_MSG_CTRL_REQ : MMC_MSG_EVT_IND);
    chk(hdr_control, c);
    chk(hdr_request_type, c[3:0]);
    if (k == 0) chk(hdr_requester_mac, a);
    chk(hdr_value_length, 1);
    if (k > 0) chk(hdr_ack_requested, k == 2);
    chk(hdr_type, k == 0 ? MMC_MSG_CTRL_REQ : MMC_MSG_EVT_IND);
    chk(hdr_compressed, 0);
    chk_q(vq, {15'h100 | v});
    chk_q(i_peer.got, eq);
    vq = {}; i_peer.got = {};
  endtask
  task final_report;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    logic [7:0] c, p;
    void'($urandom(32'h0c27));
    repeat (20) @(posedge ref_clk);
    reset <= 0;
    @(posedge ref_clk);
    wr(MMC_REG_CTRL, 32'h1);
    rd(MMC_REG_CTRL, 32'h1);
    rd(4'h2, 32'h0);
    for (int k = 1; k < 4; k++) run(k % 3);
    wr(MMC_REG_CTRL, 32'h3);
    // N=4, M=3: three of 4'ha, then one literal 4'h5, then end
    m = {8'h05, 8'h00, 8'h06, 8'h00, 8'h43, 8'h74, 8'h00, 8'h54, 8'h00, 8'h00};
    eq = {};
    send(MMC_MSG_EVT_IND);
    chk_q(pq, {15'ha, 15'ha, 15'ha, 15'h5});
    chk(dones, 1);
    chk(hdr_compressed, 1);
    // A skipped confirm must not swallow the start of the next message
    send(MMC_MSG_CTRL_CNF);
    // Value holds only the width octet, so the first count starves
    m = {8'h05, 8'h00, 8'h01, 8'h00, 8'h43};
    send(MMC_MSG_EVT_IND);
    chk(errs, 1);
    c = $urandom; p = $urandom;
    evt_control <= c; evt_ack <= 1; evt_value_length <= 16'h0001; tx_pl_data <= p;
    evt_send <= 1;
    @(posedge ref_clk); evt_send <= 0;
    @(negedge ref_clk);
    chk(evt_busy, 1);
    eq = {c & 8'h0f, 8'h00, 8'h01, 8'h01, 15'h100 | p};
    for (int j = 0; j < 300 && i_peer.got.size() < 5; j++) @(posedge ref_clk);
    chk_q(i_peer.got, eq);
    rd(MMC_REG_RX_COUNT, 32'h5);
    final_report;
  end
endmodule
`default_nettype wire
